// file: hw/pio_pkg.sv
package pio_pkg;
   // ==========================================
   // geometry
   localparam int PIO_NPIN = 16;
   localparam int PIO_NCFG = 15;
   localparam int PIO_DBG_PIN = 15;
   // ==========================================
   // register byte addresses
   localparam logic [7:0] PIO_A_MODE = 8'h00;
   localparam logic [7:0] PIO_A_OTYPE = 8'h04;
   localparam logic [7:0] PIO_A_DRV = 8'h08;
   localparam logic [7:0] PIO_A_RSV = 8'h0C;
   localparam logic [7:0] PIO_A_LATCH = 8'h10;
   localparam logic [7:0] PIO_A_PADS = 8'h14;
   localparam logic [7:0] PIO_A_XBAR = 8'h18;
   // ==========================================
   // field positions in crossbar control word
   localparam int PIO_B_PUD = 7;
   localparam int PIO_B_XBE = 6;
   localparam int PIO_B_SPI = 1;
   localparam int PIO_B_UART = 0;
   // ==========================================
   // reset values
   localparam logic [15:0] PIO_R_MODE = 16'hFFFF;
   localparam logic [15:0] PIO_R_OTYPE = 16'h0000;
   localparam logic [15:0] PIO_R_DRV = 16'h0000;
   localparam logic [15:0] PIO_R_RSV = 16'h0000;
   localparam logic [15:0] PIO_R_LATCH = 16'hFFFF;
   localparam logic [7:0] PIO_R_XBAR = 8'h00;
   // ==========================================
   // fixed pin masks: serial port on 4,5; second spi on 8..11
   localparam logic [15:0] PIO_M_UART = 16'h0030;
   localparam logic [15:0] PIO_M_SPI = 16'h0F00;
   localparam logic [15:0] PIO_M_CFG = 16'h7FFF;
endpackage

// file: hw/pio_cell.sv
`timescale 1ns/1ps
`default_nettype none
module pio_cell
   import pio_pkg::*;
(
   input wire logic digital,
   input wire logic push_pull,
   input wire logic out_val,
   input wire logic drv_en,
   input wire logic pud,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic pullup_en,
   output logic rx_val
);
   // ==========================================
   // cell logic
   always_comb begin
      pad_oe = 1'b0;
      pad_out = 1'b0;
      // analog cells keep drivers off regardless of latch
      if (digital && drv_en) begin
         if (push_pull) begin
            pad_oe = 1'b1;
            pad_out = out_val;
         end else begin
            pad_oe = ~out_val;
            pad_out = 1'b0;
         end
      end
      // pull-up when digital, pud clear and not driving low
      pullup_en = digital && !pud && !(pad_oe && !pad_out);
      rx_val = digital ? pad_in : 1'b0;
   end
endmodule
`default_nettype wire

// file: hw/pio_xbar.sv
`timescale 1ns/1ps
`default_nettype none
module pio_xbar
   import pio_pkg::*;
(
   input wire logic xbar_en,
   input wire logic uart_en,
   input wire logic spi_en,
   input wire logic [15:0] reserve,
   input wire logic [15:0] uart_val,
   input wire logic [15:0] spi_val,
   input wire logic [15:0] latch,
   output logic [15:0] out_val,
   output logic [15:0] owned
);
   logic [15:0] uart_m;
   logic [15:0] spi_m;
   always_comb begin
      // fixed positions, never on reserved pins
      uart_m = (xbar_en && uart_en) ? (PIO_M_UART & ~reserve) : 16'h0000;
      spi_m = (xbar_en && spi_en) ?
         (PIO_M_SPI & ~reserve & ~uart_m) : 16'h0000;
      owned = (uart_m | spi_m) & PIO_M_CFG;
      out_val = (uart_m & uart_val) | (spi_m & spi_val) | (~owned & latch);
   end
endmodule
`default_nettype wire

// file: hw/pio_top.sv
`timescale 1ns/1ps
`default_nettype none
module pio_top
   import pio_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [15:0] pad_in,
   output logic [15:0] pad_out,
   output logic [15:0] pad_oe,
   output logic [15:0] pad_pullup,
   output logic [15:0] pad_high_drive,
   input wire logic [15:0] uart_val,
   input wire logic [15:0] spi_val,
   output logic [15:0] periph_owned,
   output logic [15:0] pin_value
);
   typedef struct packed {
      logic [15:0] pin_analog_digital_select;
      logic [15:0] pin_output_type_select;
      logic [15:0] pin_drive_strength_select;
      logic [15:0] crossbar_pin_reserve;
      logic [15:0] latch;
      logic [7:0] xbar;
      logic [15:0] pads;
      logic [31:0] rdata;
      logic wpend;
      logic [7:0] waddr;
   } pio_state_s;
   pio_state_s st;
   pio_state_s nx;
   logic [15:0] xout;
   logic [15:0] rx;
   logic [15:0] pull;
   logic [15:0] digital;
   logic [15:0] drv_en;
   logic req;

   function automatic logic [31:0] pio_read(input pio_state_s s,
                                            input logic [7:0] a);
      case (a)
         PIO_A_MODE: pio_read = {16'h0000, s.pin_analog_digital_select};
         PIO_A_OTYPE: pio_read = {16'h0000, s.pin_output_type_select};
         PIO_A_DRV: pio_read = {16'h0000, s.pin_drive_strength_select};
         PIO_A_RSV: pio_read = {16'h0000, s.crossbar_pin_reserve};
         PIO_A_LATCH: pio_read = {16'h0000, s.latch};
         PIO_A_PADS: pio_read = {16'h0000, s.pads};
         PIO_A_XBAR: pio_read = {24'h000000, s.xbar};
         default: pio_read = 32'h00000000;
      endcase
   endfunction

   // ==========================================
   // crossbar and cells
   pio_xbar u_xbar (
      .xbar_en(st.xbar[PIO_B_XBE]),
      .uart_en(st.xbar[PIO_B_UART]),
      .spi_en(st.xbar[PIO_B_SPI]),
      .reserve(st.crossbar_pin_reserve),
      .uart_val(uart_val),
      .spi_val(spi_val),
      .latch(st.latch),
      .out_val(xout),
      .owned(periph_owned)
   );

   // top pin has no analog path and is never owned by a peripheral
   assign digital = st.pin_analog_digital_select | ~PIO_M_CFG;
   assign drv_en = {PIO_NPIN{st.xbar[PIO_B_XBE]}};

   genvar gi;
   generate
      for (gi = 0; gi < PIO_NPIN; gi++) begin : g_cell
         pio_cell u_cell (
            .digital(digital[gi]),
            .push_pull(st.pin_output_type_select[gi]),
            .out_val(xout[gi]),
            .drv_en(drv_en[gi]),
            .pud(st.xbar[PIO_B_PUD]),
            .pad_in(pad_in[gi]),
            .pad_out(pad_out[gi]),
            .pad_oe(pad_oe[gi]),
            .pullup_en(pull[gi]),
            .rx_val(rx[gi])
         );
      end
   endgenerate

   assign pad_pullup = pull;
   assign pad_high_drive = st.pin_drive_strength_select;
   assign pin_value = st.pads;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st.rdata;
   assign req = hsel && hready && htrans[1];

   // ==========================================
   // next state; writes land one cycle after address phase
   always_comb begin
      nx = st;
      nx.pads = rx;
      if (st.wpend) begin
         case (st.waddr)
            PIO_A_MODE: nx.pin_analog_digital_select = hwdata[15:0];
            PIO_A_OTYPE: nx.pin_output_type_select = hwdata[15:0];
            PIO_A_DRV: nx.pin_drive_strength_select = hwdata[15:0];
            PIO_A_RSV: nx.crossbar_pin_reserve = hwdata[15:0];
            PIO_A_LATCH: nx.latch = hwdata[15:0];
            PIO_A_XBAR: nx.xbar = hwdata[7:0];
            default: nx.xbar = st.xbar;
         endcase
      end
      nx.wpend = req && hwrite;
      nx.waddr = haddr[7:0];
      if (req && !hwrite) begin
         nx.rdata = pio_read(st, haddr[7:0]);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st.pin_analog_digital_select <= PIO_R_MODE;
         st.pin_output_type_select <= PIO_R_OTYPE;
         st.pin_drive_strength_select <= PIO_R_DRV;
         st.crossbar_pin_reserve <= PIO_R_RSV;
         st.latch <= PIO_R_LATCH;
         st.xbar <= PIO_R_XBAR;
         st.pads <= 16'h0000;
         st.rdata <= 32'h00000000;
         st.wpend <= 1'b0;
         st.waddr <= 8'h00;
      end else if (ce) begin
         st <= nx;
      end
   end

   // ==========================================
   // checks
   AST_ANALOG_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && !digital[0] |=> pin_value[0] == 1'b0)
      else $error("analog pin read nonzero");
   AST_XBAR_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      !st.xbar[PIO_B_XBE] |-> pad_oe == 16'h0000)
      else $error("driver on with crossbar off");
   // every pin, so the check is live whenever any open-drain pin sinks
   AST_OD_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
      (pad_oe & ~st.pin_output_type_select & pad_out) == 16'h0000)
      else $error("open drain drove high");
   AST_PP: assert property (@(posedge hclk) disable iff (!hresetn)
      (st.xbar[PIO_B_XBE] && digital[2] && st.pin_output_type_select[2])
      |-> pad_oe[2])
      else $error("push pull not driving");
   AST_PULL_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
      (pad_oe[1] && !pad_out[1]) |-> !pad_pullup[1])
      else $error("pull-up on while low");
   AST_PUD: assert property (@(posedge hclk) disable iff (!hresetn)
      st.xbar[PIO_B_PUD] |-> pad_pullup == 16'h0000)
      else $error("pull-up on while disabled");
   AST_ANALOG_PULL: assert property (@(posedge hclk) disable iff (!hresetn)
      !digital[6] |-> !pad_pullup[6] && !pad_oe[6])
      else $error("analog pin not isolated");
   AST_RESERVE: assert property (@(posedge hclk) disable iff (!hresetn)
      (periph_owned & st.crossbar_pin_reserve) == 16'h0000)
      else $error("reserved pin given to peripheral");
   AST_READBACK: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && digital[9] |=> pin_value[9] == $past(pad_in[9]))
      else $error("digital readback wrong");
endmodule
`default_nettype wire

// file: dv/pio_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// pads: design drive, outside driver, pull-up
module pio_pad_model
   import pio_pkg::*;
(
   input wire logic [15:0] pad_out,
   input wire logic [15:0] pad_oe,
   input wire logic [15:0] pad_pullup,
   input wire logic [15:0] ext_en,
   input wire logic [15:0] ext_val,
   output logic [15:0] pad_in
);
   always_comb begin
      for (int i = 0; i < PIO_NPIN; i++) begin
         if (pad_oe[i])
            pad_in[i] = pad_out[i];
         else if (ext_en[i])
            pad_in[i] = ext_val[i];
         else if (pad_pullup[i])
            pad_in[i] = 1'b1;
         else
            pad_in[i] = ~pad_out[i]; // floating: never a stale level
      end
   end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
 failures++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top
   import pio_pkg::*;
;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
   logic [1:0] htrans = 0;
   logic [15:0] pad_in, pad_out, pad_oe, pad_pullup, pad_high_drive;
   logic [15:0] uart_val = 0, spi_val = 0, periph_owned, pin_value;
   logic [15:0] ext_en = 0, ext_val = 0, e;
   logic hreadyout, hresp;
   int failures = 0, cmp_count = 0;
   always #5 hclk = ~hclk;
   pio_top pio_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup(pad_pullup), .pad_high_drive(pad_high_drive),
      .uart_val(uart_val), .spi_val(spi_val),
      .periph_owned(periph_owned), .pin_value(pin_value));
   pio_pad_model pio_pad_model_inst (.pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val),
      .pad_in(pad_in));
   // ==========================================
   // bus access: address phase, then data phase
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      hsel <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      xfer(1'b1, a, {16'h0, d});
   endtask
   task automatic settle();
      repeat (3) @(posedge hclk);
      #1;
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      settle();
      `CHK("oe", 16'h0000, pad_oe)
      `CHK("pullup", 16'hFFFF, pad_pullup)
      `CHK("drive", 16'h0000, pad_high_drive)
      @(posedge hclk);
      xfer(1'b0, PIO_A_MODE, 0);
      `CHK("mode", 32'h0000FFFF, r)
      xfer(1'b0, PIO_A_LATCH, 0);
      `CHK("latch", 32'h0000FFFF, r)
      `CHK("hresp", 1'b0, hresp)
      wr(PIO_A_OTYPE, 16'hFFFF);
      wr(PIO_A_LATCH, 16'h00FF);
      settle();
      `CHK("oe off", 16'h0000, pad_oe)
      wr(PIO_A_XBAR, 16'h0040);
      settle();
      `CHK("oe pp", 16'hFFFF, pad_oe)
      `CHK("out pp", 16'h00FF, pad_out)
      `CHK("pu low", 16'h0000, pad_pullup & 16'hFF00)
      ext_en <= 16'h0F0F;
      ext_val <= 16'h0A0A;
      wr(PIO_A_OTYPE, 16'h0000);
      wr(PIO_A_LATCH, 16'h0F0F);
      settle();
      `CHK("oe od", 16'hF0F0, pad_oe)
      `CHK("out od", 16'h0000, pad_out & pad_oe)
      `CHK("pu od", 16'h0F0F, pad_pullup)
      xfer(1'b0, PIO_A_PADS, 0);
      `CHK("pads", 32'h00000A0A, r)
      wr(PIO_A_XBAR, 16'h00C0);
      settle();
      `CHK("pu gd", 16'h0000, pad_pullup)
      // software parks analog pins: open drain, latch high
      ext_en <= 16'h7FFF;
      ext_val <= 16'h7FFF;
      wr(PIO_A_MODE, 16'h0000);
      wr(PIO_A_LATCH, 16'hFFFF);
      wr(PIO_A_XBAR, 16'h0040);
      settle();
      `CHK("pu an", 16'h8000, pad_pullup)
      `CHK("pinval", 16'h8000, pin_value)
      xfer(1'b0, PIO_A_PADS, 0);
      `CHK("pads an", 32'h00008000, r)
      wr(PIO_A_DRV, 16'h1234);
      settle();
      `CHK("hdrv", 16'h1234, pad_high_drive)
      ext_en <= 16'h0000;
      uart_val <= 16'hFFFF;
      spi_val <= 16'hFFFF;
      wr(PIO_A_MODE, 16'hFFFF);
      wr(PIO_A_OTYPE, 16'hFFFF);
      wr(PIO_A_LATCH, 16'h0000);
      for (int c = 1; c < 4; c++) begin
         for (int k = 0; k < 2; k++) begin
            e = ((c[0] ? PIO_M_UART : 16'h0) | (c[1] ? PIO_M_SPI : 16'h0))
               & (k ? 16'hFEEF : 16'hFFFF);
            wr(PIO_A_XBAR, 16'h0040 | c[15:0]);
            wr(PIO_A_RSV, k ? 16'h0110 : 16'h0000);
            settle();
            `CHK("owned", e, periph_owned)
            `CHK("xout", e, pad_out)
         end
      end
      @(posedge hclk);
      wr(8'h1C, 16'h5555);
      xfer(1'b0, 8'h1C, 0);
      `CHK("unmapped", 32'h00000000, r)
      xfer(1'b0, PIO_A_DRV, 0);
      `CHK("drv rd", 32'h00001234, r)
      give_verdict();
   end
   initial begin
      #100000;
      failures++;
      give_verdict();
   end
endmodule
`default_nettype wire
